//--- scbd_decoder.sv
// Control block command decoder and executor
`timescale 1ns/1ps

module scbd_decoder (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic cb_valid,
	input wire logic [15:0] cb_word,
	output logic cb_ready,
	output logic tgt_cmd_valid,
	output scbd_pkg::scbd_op_t tgt_op,
	output logic [31:0] tgt_lba,
	output logic [15:0] tgt_count,
	output logic [15:0] tgt_block_len,
	input wire logic tgt_done,
	input wire logic tgt_byte_valid,
	input wire logic [7:0] tgt_byte,
	input wire logic tgt_byte_last,
	output logic mem_rd_req,
	output logic mem_wr_valid,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_wr_data,
	input wire logic mem_rd_valid,
	input wire logic [7:0] mem_rd_data,
	output logic host_irq,
	output logic cmd_invalid,
	output logic disconnect_inhibit_flag,
	output logic sync_inhibit_flag,
	output logic status_expand_option,
	output logic retry_option,
	output logic list_pointer_option,
	output logic buffer_bypass_option,
	output logic chain_option,
	output logic suppress_option,
	output logic [31:0] cap_last_lba,
	output logic [31:0] cap_block_len,
	output logic address_valid_flag,
	output logic [2:0] sense_class,
	output logic [3:0] sense_code,
	output logic [7:0] sense_segment,
	output logic filemark_flag,
	output logic end_of_medium_flag,
	output logic length_mismatch_flag,
	output logic [3:0] sense_key,
	output logic [31:0] sense_info,
	output logic [7:0] sense_addl_len
);
	import scbd_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		scbd_state_t state;
		logic [3:0] widx;
		logic [SCBD_CB_WORDS-1:0][15:0] words;
		logic [15:0] offset;
		logic [15:0] dlen;
		logic [31:0] acc;
		logic cb_ready;
		logic tgt_cmd_valid;
		scbd_op_t tgt_op;
		logic [31:0] tgt_lba;
		logic [15:0] tgt_count;
		logic [15:0] tgt_block_len;
		logic mem_rd_req;
		logic mem_wr_valid;
		logic [31:0] mem_addr;
		logic [7:0] mem_wr_data;
		logic host_irq;
		logic cmd_invalid;
		logic [15:0] cmd_flags;
		logic [15:0] enable_flags;
		logic [31:0] cap_lba;
		logic [31:0] cap_len;
		logic [7:0] sb0;
		logic [7:0] sb1;
		logic [7:0] sb2;
		logic [31:0] info;
		logic [7:0] addl;
	} scbd_regs_t;

	scbd_regs_t r_reg;
	scbd_regs_t r_next;

	// ==========================================
	// Command decode
	logic [15:0] cmd_w;
	logic in_group;
	logic dec_read;
	logic dec_cap;
	logic dec_ver;
	logic dec_sense;
	logic dec_reassign;
	logic [31:0] buf_addr;
	logic [31:0] ver_bytes;
	logic ver_over;

	assign cmd_w = r_reg.words[SCBD_W_CMD];
	assign in_group = cmd_w[15:8] == SCBD_CMD_GROUP && cmd_w[5:4] == 2'b00;
	assign dec_read = in_group && cmd_w[3:0] == SCBD_LO_READ[3:0];
	assign dec_cap = in_group && cmd_w[3:0] == SCBD_LO_CAPACITY[3:0];
	assign dec_ver = in_group && cmd_w[3:0] == SCBD_LO_VERIFY[3:0];
	assign dec_sense = in_group && cmd_w[3:0] == SCBD_LO_SENSE[3:0];
	assign dec_reassign = cmd_w == SCBD_REASSIGN_WORD;
	assign buf_addr = {r_reg.words[SCBD_W_BUF_HI], r_reg.words[SCBD_W_BUF_LO]};
	assign ver_bytes = r_reg.words[SCBD_W_BLK_CNT] * r_reg.words[SCBD_W_BLK_LEN];
	assign ver_over = ver_bytes > SCBD_MAX_XFER;

	// ==========================================
	// Next state
	always_comb begin
		r_next = r_reg;
		r_next.tgt_cmd_valid = 1'b0;
		r_next.mem_rd_req = 1'b0;
		r_next.mem_wr_valid = 1'b0;
		r_next.host_irq = 1'b0;
		r_next.cmd_invalid = 1'b0;
		case (r_reg.state)
			SCBD_ST_IDLE: begin
				if (cb_valid) begin
					r_next.words[r_reg.widx] = cb_word;
					if (r_reg.widx == 4'(SCBD_CB_WORDS - 1)) begin
						r_next.widx = 4'h0;
						r_next.state = SCBD_ST_DECODE;
					end else begin
						r_next.widx = r_reg.widx + 4'h1;
					end
				end
			end
			SCBD_ST_DECODE: begin
				r_next.cmd_flags = cmd_w;
				r_next.enable_flags = r_reg.words[SCBD_W_ENABLE];
				r_next.tgt_lba = {r_reg.words[SCBD_W_LBA_HI], r_reg.words[SCBD_W_LBA_LO]};
				r_next.tgt_count = r_reg.words[SCBD_W_BLK_CNT];
				r_next.tgt_block_len = r_reg.words[SCBD_W_BLK_LEN];
				r_next.offset = 16'h0000;
				r_next.state = SCBD_ST_TGT_ISSUE;
				if (dec_reassign) begin
					r_next.tgt_op = SCBD_OP_REASSIGN;
					r_next.dlen = 16'h0000;
					r_next.state = SCBD_ST_RD_REQ;
				end else if (dec_cap) begin
					r_next.tgt_op = SCBD_OP_CAPACITY;
					r_next.tgt_count = SCBD_CAP_BYTES;
				end else if (dec_ver && !ver_over) begin
					r_next.tgt_op = SCBD_OP_VERIFY;
				end else if (dec_sense) begin
					r_next.tgt_op = SCBD_OP_SENSE;
					r_next.tgt_count = {8'h00, r_reg.words[SCBD_W_CNT_LO][7:0]};
				end else if (dec_read) begin
					r_next.tgt_op = SCBD_OP_READ;
				end else begin
					r_next.tgt_op = SCBD_OP_NONE;
					r_next.cmd_invalid = 1'b1;
					r_next.state = SCBD_ST_DONE;
				end
			end
			SCBD_ST_TGT_ISSUE: begin
				r_next.tgt_cmd_valid = 1'b1;
				if (r_reg.tgt_op == SCBD_OP_CAPACITY || r_reg.tgt_op == SCBD_OP_SENSE) begin
					r_next.offset = 16'h0000;
					r_next.state = SCBD_ST_TGT_BYTES;
				end else begin
					r_next.state = SCBD_ST_TGT_WAIT;
				end
			end
			SCBD_ST_TGT_WAIT: begin
				if (tgt_done) begin
					if (r_reg.tgt_op == SCBD_OP_REASSIGN
						&& r_reg.offset != r_reg.dlen + SCBD_DEFECT_HDR) begin
						r_next.state = SCBD_ST_RD_REQ;
					end else begin
						r_next.state = SCBD_ST_DONE;
					end
				end
			end
			SCBD_ST_TGT_BYTES: begin
				if (tgt_byte_valid) begin
					r_next.mem_wr_valid = 1'b1;
					r_next.mem_addr = buf_addr + {16'h0000, r_reg.offset};
					r_next.mem_wr_data = tgt_byte;
					r_next.offset = r_reg.offset + 16'h0001;
					if (r_reg.tgt_op == SCBD_OP_CAPACITY) begin
						if (r_reg.offset < SCBD_DEFECT_HDR) begin
							r_next.cap_lba = {r_reg.cap_lba[23:0], tgt_byte};
						end else begin
							r_next.cap_len = {r_reg.cap_len[23:0], tgt_byte};
						end
					end else begin
						if (r_reg.offset == SCBD_SENSE_B0) begin
							r_next.sb0 = tgt_byte;
						end
						if (r_reg.offset == SCBD_SENSE_B1) begin
							r_next.sb1 = tgt_byte;
						end
						if (r_reg.offset == SCBD_SENSE_B2) begin
							r_next.sb2 = tgt_byte;
						end
						if (r_reg.offset > SCBD_SENSE_B2 && r_reg.offset < SCBD_SENSE_ADDL) begin
							r_next.info = {r_reg.info[23:0], tgt_byte};
						end
						if (r_reg.offset == SCBD_SENSE_ADDL) begin
							r_next.addl = tgt_byte;
						end
					end
					if (tgt_byte_last || r_reg.offset + 16'h0001 == r_reg.tgt_count) begin
						r_next.state = SCBD_ST_DONE;
					end
				end
			end
			SCBD_ST_RD_REQ: begin
				r_next.mem_rd_req = 1'b1;
				r_next.mem_addr = buf_addr + {16'h0000, r_reg.offset};
				r_next.state = SCBD_ST_RD_WAIT;
			end
			SCBD_ST_RD_WAIT: begin
				if (mem_rd_valid) begin
					r_next.offset = r_reg.offset + 16'h0001;
					r_next.state = SCBD_ST_RD_REQ;
					if (r_reg.offset == 16'h0002) begin
						r_next.dlen[15:8] = mem_rd_data;
					end
					if (r_reg.offset == 16'h0003) begin
						r_next.dlen[7:0] = mem_rd_data;
						if ({r_reg.dlen[15:8], mem_rd_data} == 16'h0000) begin
							r_next.state = SCBD_ST_DONE;
						end
					end
					if (r_reg.offset >= SCBD_DEFECT_HDR) begin
						r_next.acc = {r_reg.acc[23:0], mem_rd_data};
						if (r_reg.offset[1:0] == 2'b11) begin
							r_next.tgt_lba = {r_reg.acc[23:0], mem_rd_data};
							r_next.tgt_count = 16'h0001;
							r_next.state = SCBD_ST_TGT_ISSUE;
						end
					end
				end
			end
			SCBD_ST_DONE: begin
				r_next.host_irq = 1'b1;
				r_next.state = SCBD_ST_IDLE;
			end
			default: begin
				r_next.state = SCBD_ST_IDLE;
			end
		endcase
		r_next.cb_ready = r_next.state == SCBD_ST_IDLE;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r_reg <= '0;
			r_reg.cb_ready <= 1'b1;
		end else if (clk_en) begin
			r_reg <= r_next;
		end
	end

	// ==========================================
	// Outputs
	assign cb_ready = r_reg.cb_ready;
	assign tgt_cmd_valid = r_reg.tgt_cmd_valid;
	assign tgt_op = r_reg.tgt_op;
	assign tgt_lba = r_reg.tgt_lba;
	assign tgt_count = r_reg.tgt_count;
	assign tgt_block_len = r_reg.tgt_block_len;
	assign mem_rd_req = r_reg.mem_rd_req;
	assign mem_wr_valid = r_reg.mem_wr_valid;
	assign mem_addr = r_reg.mem_addr;
	assign mem_wr_data = r_reg.mem_wr_data;
	assign host_irq = r_reg.host_irq;
	assign cmd_invalid = r_reg.cmd_invalid;
	assign disconnect_inhibit_flag = r_reg.cmd_flags[SCBD_B_DISC_INH];
	assign sync_inhibit_flag = r_reg.cmd_flags[SCBD_B_SYNC_INH];
	assign status_expand_option = r_reg.enable_flags[SCBD_B_STATUS_EXPAND];
	assign retry_option = r_reg.enable_flags[SCBD_B_RETRY];
	assign list_pointer_option = r_reg.enable_flags[SCBD_B_LIST_PTR];
	assign buffer_bypass_option = r_reg.enable_flags[SCBD_B_BYPASS];
	assign chain_option = r_reg.enable_flags[SCBD_B_CHAIN];
	assign suppress_option = r_reg.enable_flags[SCBD_B_SUPPRESS];
	assign cap_last_lba = r_reg.cap_lba;
	assign cap_block_len = r_reg.cap_len;
	assign address_valid_flag = r_reg.sb0[7];
	assign sense_class = r_reg.sb0[6:4];
	assign sense_code = r_reg.sb0[3:0];
	assign sense_segment = r_reg.sb1;
	assign filemark_flag = r_reg.sb2[7];
	assign end_of_medium_flag = r_reg.sb2[6];
	assign length_mismatch_flag = r_reg.sb2[5];
	assign sense_key = r_reg.sb2[3:0];
	assign sense_info = r_reg.info;
	assign sense_addl_len = r_reg.addl;

	// ==========================================
	// Checks
	logic in_dec;
	logic any_dec;
	assign in_dec = r_reg.state == SCBD_ST_DECODE;
	assign any_dec = dec_reassign || dec_cap || dec_ver || dec_sense || dec_read;

	sequence s_issue(scbd_op_t op);
		tgt_op == op ##1 tgt_cmd_valid && tgt_op == op;
	endsequence

	property p_cap_issue;
		@(posedge clk) disable iff (reset || !clk_en)
		in_dec && dec_cap |=> s_issue(SCBD_OP_CAPACITY) ##0 tgt_count == SCBD_CAP_BYTES;
	endproperty
	a_cap_issue: assert property (p_cap_issue) else $error("capacity query not issued");

	property p_byte_copy;
		@(posedge clk) disable iff (reset || !clk_en)
		r_reg.state == SCBD_ST_TGT_BYTES && tgt_byte_valid
			|=> mem_wr_valid && mem_wr_data == $past(tgt_byte);
	endproperty
	a_byte_copy: assert property (p_byte_copy) else $error("target byte not copied");

	property p_verify_no_write;
		@(posedge clk) disable iff (reset || !clk_en)
		tgt_op == SCBD_OP_VERIFY |-> !mem_wr_valid;
	endproperty
	a_verify_no_write: assert property (p_verify_no_write) else $error("verify wrote memory");

	property p_verify_issue;
		@(posedge clk) disable iff (reset || !clk_en)
		in_dec && dec_ver && !ver_over |=> s_issue(SCBD_OP_VERIFY)
			##0 tgt_lba == $past({r_reg.words[SCBD_W_LBA_HI], r_reg.words[SCBD_W_LBA_LO]}, 2);
	endproperty
	a_verify_issue: assert property (p_verify_issue) else $error("verify not issued");

	property p_verify_limit;
		@(posedge clk) disable iff (reset || !clk_en)
		in_dec && dec_ver && ver_over |=> cmd_invalid ##1 host_irq;
	endproperty
	a_verify_limit: assert property (p_verify_limit) else $error("verify limit not enforced");

	property p_reassign_fetch;
		@(posedge clk) disable iff (reset || !clk_en)
		in_dec && dec_reassign |=> ##1 mem_rd_req && mem_addr == buf_addr;
	endproperty
	a_reassign_fetch: assert property (p_reassign_fetch) else $error("defect list not fetched");

	sequence s_last_sense;
		r_reg.state == SCBD_ST_TGT_BYTES && tgt_op == SCBD_OP_SENSE
			&& tgt_byte_valid && tgt_byte_last;
	endsequence

	property p_sense_irq;
		@(posedge clk) disable iff (reset || !clk_en)
		s_last_sense |=> mem_wr_valid && !host_irq ##1 host_irq;
	endproperty
	a_sense_irq: assert property (p_sense_irq) else $error("sense interrupt misplaced");

	property p_invalid;
		@(posedge clk) disable iff (reset || !clk_en)
		in_dec && !any_dec |=> cmd_invalid && !tgt_cmd_valid ##1 host_irq;
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid command not rejected");

	property p_sense_key;
		@(posedge clk) disable iff (reset || !clk_en)
		r_reg.state == SCBD_ST_TGT_BYTES && tgt_op == SCBD_OP_SENSE && tgt_byte_valid
			&& r_reg.offset == SCBD_SENSE_B2 |=> sense_key == $past(tgt_byte[3:0]);
	endproperty
	a_sense_key: assert property (p_sense_key) else $error("sense key not captured");
endmodule

//--- scbd_far.sv
// Far-side model: target device and host memory
`timescale 1ns/1ps
module scbd_far
	import scbd_pkg::*;
(
	input wire logic clk,
	input wire logic tgt_cmd_valid,
	input wire scbd_pkg::scbd_op_t tgt_op,
	input wire logic [15:0] tgt_count,
	input wire logic mem_rd_req,
	input wire logic [31:0] mem_addr,
	output logic tgt_done,
	output logic tgt_byte_valid,
	output logic [7:0] tgt_byte,
	output logic tgt_byte_last,
	output logic mem_rd_valid,
	output logic [7:0] mem_rd_data
);
	int lat = 0;
	int n;
	logic [7:0] a;
	logic [7:0] mem [256];
	initial begin
		tgt_done = 1'b0;
		tgt_byte_valid = 1'b0;
		tgt_byte = 8'hA5;
		tgt_byte_last = 1'b0;
		mem_rd_valid = 1'b0;
		mem_rd_data = 8'h5A;
	end
	// ==========================================
	// Target: byte stream or done pulse
	always @(posedge clk) begin
		if (tgt_cmd_valid) begin
			if (tgt_op == SCBD_OP_CAPACITY || tgt_op == SCBD_OP_SENSE) begin
				n = (tgt_op == SCBD_OP_CAPACITY) ? 8 : int'(tgt_count);
				for (int k = 0; k < n; k++) begin
					#1;
					tgt_byte_valid = 1'b1;
					tgt_byte = mem[8'(128 + k)];
					tgt_byte_last = (k == n - 1);
					@(posedge clk);
					if (lat > 0 || k == n - 1) begin
						#1;
						tgt_byte_valid = 1'b0;
						tgt_byte = ~tgt_byte;
						tgt_byte_last = 1'b0;
						repeat (lat) @(posedge clk);
					end
				end
			end else begin
				repeat (lat) @(posedge clk);
				#1;
				tgt_done = 1'b1;
				@(posedge clk);
				#1;
				tgt_done = 1'b0;
			end
		end
	end
	// ==========================================
	// Host memory: read answers
	always @(posedge clk) begin
		if (mem_rd_req) begin
			a = mem_addr[7:0];
			repeat (lat) @(posedge clk);
			#1;
			mem_rd_valid = 1'b1;
			mem_rd_data = mem[a];
			@(posedge clk);
			#1;
			mem_rd_valid = 1'b0;
			mem_rd_data = ~mem_rd_data;
		end
	end
endmodule

//--- scbd_pkg.sv
// Constants and types shared by the control block decoder
package scbd_pkg;
	// ==========================================
	// Control block word positions
	localparam int SCBD_CB_WORDS = 14;
	localparam logic [3:0] SCBD_W_CMD = 4'h0;
	localparam logic [3:0] SCBD_W_ENABLE = 4'h1;
	localparam logic [3:0] SCBD_W_LBA_LO = 4'h2;
	localparam logic [3:0] SCBD_W_LBA_HI = 4'h3;
	localparam logic [3:0] SCBD_W_BUF_LO = 4'h4;
	localparam logic [3:0] SCBD_W_BUF_HI = 4'h5;
	localparam logic [3:0] SCBD_W_CNT_LO = 4'h6;
	localparam logic [3:0] SCBD_W_BLK_CNT = 4'hC;
	localparam logic [3:0] SCBD_W_BLK_LEN = 4'hD;
	// ==========================================
	// Command word patterns
	localparam logic [7:0] SCBD_CMD_GROUP = 8'h1C;
	localparam logic [5:0] SCBD_LO_READ = 6'h01;
	localparam logic [5:0] SCBD_LO_VERIFY = 6'h03;
	localparam logic [5:0] SCBD_LO_SENSE = 6'h08;
	localparam logic [5:0] SCBD_LO_CAPACITY = 6'h09;
	localparam logic [15:0] SCBD_REASSIGN_WORD = 16'h1C18;
	// ==========================================
	// Flag positions
	localparam int SCBD_B_DISC_INH = 7;
	localparam int SCBD_B_SYNC_INH = 6;
	localparam int SCBD_B_ENABLE_WORD = 15;
	localparam int SCBD_B_STATUS_EXPAND = 14;
	localparam int SCBD_B_RETRY = 13;
	localparam int SCBD_B_LIST_PTR = 12;
	localparam int SCBD_B_SUPPRESS = 10;
	localparam int SCBD_B_BYPASS = 9;
	localparam int SCBD_B_CHAIN = 0;
	// ==========================================
	// Data structure sizes and limits
	localparam logic [15:0] SCBD_CAP_BYTES = 16'h0008;
	localparam logic [15:0] SCBD_DEFECT_HDR = 16'h0004;
	localparam logic [31:0] SCBD_MAX_XFER = 32'h00FF_FFFF;
	localparam logic [15:0] SCBD_SENSE_B0 = 16'h0000;
	localparam logic [15:0] SCBD_SENSE_B1 = 16'h0001;
	localparam logic [15:0] SCBD_SENSE_B2 = 16'h0002;
	localparam logic [15:0] SCBD_SENSE_ADDL = 16'h0007;
	localparam logic [2:0] SCBD_CLASS_EXT = 3'h7;
	// ==========================================
	// Target operations and states
	typedef enum logic [2:0] {
		SCBD_OP_NONE = 3'b000,
		SCBD_OP_READ = 3'b001,
		SCBD_OP_CAPACITY = 3'b010,
		SCBD_OP_VERIFY = 3'b011,
		SCBD_OP_REASSIGN = 3'b100,
		SCBD_OP_SENSE = 3'b101
	} scbd_op_t;
	typedef enum logic [2:0] {
		SCBD_ST_IDLE = 3'b000,
		SCBD_ST_DECODE = 3'b001,
		SCBD_ST_TGT_ISSUE = 3'b010,
		SCBD_ST_TGT_WAIT = 3'b011,
		SCBD_ST_TGT_BYTES = 3'b100,
		SCBD_ST_RD_REQ = 3'b101,
		SCBD_ST_RD_WAIT = 3'b110,
		SCBD_ST_DONE = 3'b111
	} scbd_state_t;
endpackage

//--- tb_storage_control_block_decoder.sv
// Self-checking bench for the control block decoder
`timescale 1ns/1ps
module tb_storage_control_block_decoder;
	import scbd_pkg::*;
	logic clk, reset, clk_en, cb_valid, cb_ready, tgt_cmd_valid, tgt_done, tgt_byte_valid;
	logic tgt_byte_last, mem_rd_req, mem_wr_valid, mem_rd_valid, host_irq, cmd_invalid;
	logic disconnect_inhibit_flag, sync_inhibit_flag, status_expand_option, retry_option;
	logic list_pointer_option, buffer_bypass_option, chain_option, suppress_option;
	logic address_valid_flag, filemark_flag, end_of_medium_flag, length_mismatch_flag;
	logic [15:0] cb_word, tgt_count, tgt_block_len;
	logic [31:0] tgt_lba, mem_addr, cap_last_lba, cap_block_len, sense_info;
	logic [7:0] tgt_byte, mem_wr_data, mem_rd_data, sense_segment, sense_addl_len;
	logic [2:0] sense_class;
	logic [3:0] sense_code, sense_key;
	scbd_op_t tgt_op;
	int failures = 0, n_compared = 0, n_irq = 0, n_inv = 0, cyc = 0, irq_cyc = 0, wr_cyc = 0;
	logic [31:0] seed = 32'h25B3;
	logic [15:0] cb [14];
	logic [31:0] q_op[$], q_lba[$], q_cnt[$], q_wa[$], q_wd[$];
	logic [31:0] e_op[$], e_lba[$], e_cnt[$], e_wa[$], e_wd[$];
	logic [15:0] bad [5] = '{16'h1CD8, 16'h1C05, 16'h1D03, 16'h0C09, 16'h1C3F};

	scbd_decoder u_scbd_decoder (.clk(clk), .reset(reset), .clk_en(clk_en),
		.cb_valid(cb_valid), .cb_word(cb_word), .cb_ready(cb_ready),
		.tgt_cmd_valid(tgt_cmd_valid), .tgt_op(tgt_op), .tgt_lba(tgt_lba),
		.tgt_count(tgt_count), .tgt_block_len(tgt_block_len), .tgt_done(tgt_done),
		.tgt_byte_valid(tgt_byte_valid), .tgt_byte(tgt_byte), .tgt_byte_last(tgt_byte_last),
		.mem_rd_req(mem_rd_req), .mem_wr_valid(mem_wr_valid), .mem_addr(mem_addr),
		.mem_wr_data(mem_wr_data), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
		.host_irq(host_irq), .cmd_invalid(cmd_invalid),
		.disconnect_inhibit_flag(disconnect_inhibit_flag), .sync_inhibit_flag(sync_inhibit_flag),
		.status_expand_option(status_expand_option), .retry_option(retry_option),
		.list_pointer_option(list_pointer_option), .buffer_bypass_option(buffer_bypass_option),
		.chain_option(chain_option), .suppress_option(suppress_option),
		.cap_last_lba(cap_last_lba), .cap_block_len(cap_block_len),
		.address_valid_flag(address_valid_flag), .sense_class(sense_class),
		.sense_code(sense_code), .sense_segment(sense_segment), .filemark_flag(filemark_flag),
		.end_of_medium_flag(end_of_medium_flag), .length_mismatch_flag(length_mismatch_flag),
		.sense_key(sense_key), .sense_info(sense_info), .sense_addl_len(sense_addl_len));

	scbd_far u_scbd_far (.clk(clk), .tgt_cmd_valid(tgt_cmd_valid), .tgt_op(tgt_op),
		.tgt_count(tgt_count), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
		.tgt_done(tgt_done), .tgt_byte_valid(tgt_byte_valid), .tgt_byte(tgt_byte),
		.tgt_byte_last(tgt_byte_last), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));

	// ==========================================
	// Clock, monitor and timeout
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (mem_wr_valid === 1'b1) begin
			q_wa.push_back(mem_addr);
			q_wd.push_back({24'h0, mem_wr_data});
			wr_cyc = cyc;
		end
		if (tgt_cmd_valid === 1'b1) begin
			q_op.push_back({29'h0, tgt_op});
			q_lba.push_back(tgt_lba);
			q_cnt.push_back({tgt_block_len, tgt_count});
		end
		if (host_irq === 1'b1) begin
			n_irq++;
			irq_cyc = cyc;
		end
		if (cmd_invalid === 1'b1)
			n_inv++;
		if (cyc > 20000) begin
			failures++;
			finish_test();
		end
	end
	// ==========================================
	// Helpers
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function automatic logic [31:0] m4(input int o);
		return {u_scbd_far.mem[o], u_scbd_far.mem[o + 1],
			u_scbd_far.mem[o + 2], u_scbd_far.mem[o + 3]};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task finish_test();
		if (failures == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task mk(input logic [15:0] cmd, input logic [15:0] en);
		for (int i = 0; i < 14; i++)
			cb[i] = rnd();
		cb[0] = cmd;
		cb[1] = en;
	endtask
	task eop(input logic [2:0] op, input logic [31:0] lba, input logic [31:0] cnt);
		e_op.push_back({29'h0, op});
		e_lba.push_back(lba);
		e_cnt.push_back(cnt);
	endtask
	task exp_wr(input int n);
		for (int k = 0; k < n; k++) begin
			e_wa.push_back({cb[5], cb[4]} + 32'(k));
			e_wd.push_back({24'h0, u_scbd_far.mem[128 + k]});
		end
	endtask
	task run(input int inv);
		int i0, v0, k;
		logic r;
		q_op.delete();
		q_lba.delete();
		q_cnt.delete();
		q_wa.delete();
		q_wd.delete();
		i0 = n_irq;
		v0 = n_inv;
		k = 0;
		u_scbd_far.lat = int'(rnd() % 16'h0003);
		cb_valid = 1'b1;
		while (k < 14) begin
			cb_word = cb[k];
			r = cb_ready;
			@(posedge clk);
			#1;
			if (r === 1'b1)
				k++;
		end
		cb_valid = 1'b0;
		cb_word = rnd();
		// Freeze the decode step for two cycles
		clk_en = 1'b0;
		repeat (2) begin
			@(posedge clk);
			#1;
		end
		chk({cb_ready, cmd_invalid, tgt_cmd_valid, host_irq}, 0);
		clk_en = 1'b1;
		for (int t = 0; t < 3000 && n_irq == i0; t++) begin
			@(posedge clk);
			#1;
		end
		chk(n_irq - i0, 1);
		chk(n_inv - v0, inv);
		chk(q_op.size(), e_op.size());
		chk(q_wa.size(), e_wa.size());
		foreach (e_op[i]) begin
			chk(q_op[i], e_op[i]);
			chk(q_lba[i], e_lba[i]);
			chk(q_cnt[i], e_cnt[i]);
		end
		foreach (e_wa[i]) begin
			chk(q_wa[i], e_wa[i]);
			chk(q_wd[i], e_wd[i]);
		end
		e_op.delete();
		e_lba.delete();
		e_cnt.delete();
		e_wa.delete();
		e_wd.delete();
		@(posedge clk);
		#1;
		chk(cb_ready, 1);
	endtask
	// ==========================================
	// Scenarios
	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		cb_valid = 1'b0;
		cb_word = 16'h0000;
		repeat (3) @(posedge clk);
		#1;
		reset = 1'b0;
		for (int i = 0; i < 4; i++) begin
			mk(16'h1C01 | (rnd() & 16'h00C0), 16'h8000 | (rnd() & 16'h7601));
			eop(SCBD_OP_READ, {cb[3], cb[2]}, {cb[13], cb[12]});
			run(0);
			chk({26'h0, status_expand_option, retry_option, list_pointer_option, suppress_option,
				buffer_bypass_option, chain_option}, {cb[1][14:12], cb[1][10:9], cb[1][0]});
		end
		for (int i = 0; i < 3; i++) begin
			mk(16'h1C09 | (rnd() & 16'h00C0), 16'h8200);
			for (int k = 0; k < 8; k++)
				u_scbd_far.mem[128 + k] = 8'(rnd());
			exp_wr(8);
			eop(SCBD_OP_CAPACITY, {cb[3], cb[2]}, {cb[13], 16'h0008});
			run(0);
			chk(cap_last_lba, m4(128));
			chk(cap_block_len, m4(132));
			chk({disconnect_inhibit_flag, sync_inhibit_flag}, cb[0][7:6]);
		end
		// Fixed-block verify targets
		for (int i = 0; i < 3; i++) begin
			mk(16'h1C03 | (rnd() & 16'h00C0), 16'h8200);
			cb[12] = (i == 2) ? (rnd() & 16'h00FF) : 16'hFFFF;
			cb[13] = (i == 0) ? 16'h0100 : ((i == 1) ? 16'h0101 : 16'h0200);
			if (i != 1)
				eop(SCBD_OP_VERIFY, {cb[3], cb[2]}, {cb[13], cb[12]});
			run(i == 1);
		end
		for (int n = 0; n < 3; n++) begin
			mk(16'h1C18, 16'h0200 | (rnd() & 16'h6001));
			cb[4] = {cb[4][15:8], 8'h10};
			u_scbd_far.mem[16] = 8'h00;
			u_scbd_far.mem[17] = 8'h00;
			u_scbd_far.mem[18] = 8'h00;
			u_scbd_far.mem[19] = 8'(4 * n);
			for (int k = 0; k < 4 * n; k++)
				u_scbd_far.mem[20 + k] = 8'(rnd());
			for (int d = 0; d < n; d++)
				eop(SCBD_OP_REASSIGN, m4(20 + 4 * d), {cb[13], 16'h0001});
			run(0);
		end
		// Sense taken as if after check condition
		for (int key = 0; key < 9; key++) begin
			mk(16'h1C08 | (rnd() & 16'h00C0), 16'h8200 | (rnd() & 16'h6400));
			cb[6] = {cb[6][15:8], 8'h08};
			for (int k = 0; k < 8; k++)
				u_scbd_far.mem[128 + k] = 8'(rnd());
			u_scbd_far.mem[128][6:4] = 3'h7;
			u_scbd_far.mem[130][3:0] = 4'(key);
			exp_wr(8);
			eop(SCBD_OP_SENSE, {cb[3], cb[2]}, {cb[13], 16'h0008});
			run(0);
			chk(irq_cyc, wr_cyc + 1);
			chk({address_valid_flag, sense_class, sense_code, sense_segment},
				m4(128) >> 16);
			chk({filemark_flag, end_of_medium_flag, length_mismatch_flag, sense_key},
				{u_scbd_far.mem[130][7:5], u_scbd_far.mem[130][3:0]});
			chk(sense_info, m4(131));
			chk(sense_addl_len, u_scbd_far.mem[135]);
		end
		foreach (bad[i]) begin
			mk(bad[i], 16'h8200);
			run(1);
		end
		finish_test();
	end
endmodule
